// File: dv/fgc_host.sv
// Host model that drives the three-wire serial programming port
module fgc_host (
   output logic      latch_enable,
   output logic      serial_clk,
   output logic      serial_data_in,
   input  wire logic serial_readback_out
);
   timeunit 1ns;
   timeprecision 100ps;

   // ---------------------------------------------------------------------
   // Link timing
   // ---------------------------------------------------------------------
   localparam realtime HALF = 62.5;   // Half of the 125 ns link period, no relation to ref_clk
   localparam realtime SKEW = 0.3;    // Start offset so no link edge meets a ref_clk edge

   // Port closed, clock parked low between frames
   initial begin
      latch_enable   = 1'b1;
      serial_clk     = 1'b0;
      serial_data_in = 1'b0;
   end

   // ---------------------------------------------------------------------
   // One frame: wr picks the type, nbits bits go out or come back LSB first
   // ---------------------------------------------------------------------
   task automatic xfer(input logic wr, input logic [7:0] d, input int nbits, output logic [7:0] q);
      #SKEW;
      q = 8'h00;
      latch_enable = 1'b0;
      #HALF;
      serial_data_in = wr;
      #HALF;
      serial_clk = 1'b1;
      #HALF;
      serial_clk = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         // Reads leave the data line toggling so a stale level is never mistaken for a bit
         serial_data_in = wr ? d[i] : ~serial_data_in;
         #HALF;
         q[i] = serial_readback_out;
         serial_clk = 1'b1;
         #HALF;
         serial_clk = 1'b0;
      end
      #HALF;
      serial_data_in = ~serial_data_in;                     // Released line carries no stale value
      latch_enable   = 1'b1;
      #HALF;
      #HALF;
   endtask : xfer

   // Clock edges with the latch high: the port must not react
   task automatic stray_clocks(input int n);
      #SKEW;
      serial_data_in = 1'b1;
      for (int i = 0; i < n; i++) begin
         #HALF;
         serial_clk = 1'b1;
         #HALF;
         serial_clk = 1'b0;
      end
      #HALF;
   endtask : stray_clocks
endmodule : fgc_host

// File: dv/tb_filter_gain_control_register.sv
// Self-checking bench for the serial filter and gain control register
module tb_filter_gain_control_register;
   timeunit 1ns;
   timeprecision 100ps;

   // ---------------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------------
   logic                ref_clk             = 1'b0;   // 250 MHz system clock
   logic                rstn                = 1'b0;   // Synchronous reset, held at start
   logic                clk_en              = 1'b1;   // Running except during the clock enable freeze test
   logic                chip_enable         = 1'b1;   // Chip enable pin
   logic                offset_loop_disable = 1'b0;   // Offset loop disable pin
   logic                latch_enable;                  // Driven by the host model
   logic                serial_clk;                    // Driven by the host model
   logic                serial_data_in;                // Driven by the host model
   logic                serial_readback_out;           // Read data from the design
   logic [1:0][4:0]     ch_corner_code;                // Per-channel corner code
   logic [1:0][2:0]     ch_gain_code;                  // Per-channel gain code
   logic [1:0]          ch_pass;                       // Per-channel pass flag
   logic                preamp_gain_sel;               // Gain select bits
   logic                postamp_gain_sel;
   logic                vga_max_gain_sel;
   logic                chip_active;                   // Synchronised enable
   logic                offset_loop_active;            // Loop running
   int                  bad_count   = 0;               // Mismatches seen
   int                  checks_done = 0;               // Comparisons made
   int                  cycles      = 0;               // Timeout counter
   int                  seed        = 86908;           // Fixed seed for repeatable runs
   logic [7:0]          word;                          // Word being written
   logic [7:0]          stored;                        // Word the design should hold
   logic [7:0]          rd;                            // Word read back
   logic [7:0]          corner [4] = '{8'h00, 8'hff, 8'ha5, 8'h08};   // Boundary words first

   // ---------------------------------------------------------------------
   // Clock, design and host
   // ---------------------------------------------------------------------
   always #2 ref_clk = ~ref_clk;

   fgc_ctrl dut (
      .ref_clk             (ref_clk),
      .rstn                (rstn),
      .clk_en              (clk_en),
      .latch_enable        (latch_enable),
      .serial_clk          (serial_clk),
      .serial_data_in      (serial_data_in),
      .chip_enable         (chip_enable),
      .offset_loop_disable (offset_loop_disable),
      .serial_readback_out (serial_readback_out),
      .ch_corner_code      (ch_corner_code),
      .ch_gain_code        (ch_gain_code),
      .ch_pass             (ch_pass),
      .preamp_gain_sel     (preamp_gain_sel),
      .postamp_gain_sel    (postamp_gain_sel),
      .vga_max_gain_sel    (vga_max_gain_sel),
      .chip_active         (chip_active),
      .offset_loop_active  (offset_loop_active)
   );

   fgc_host host (
      .latch_enable        (latch_enable),
      .serial_clk          (serial_clk),
      .serial_data_in      (serial_data_in),
      .serial_readback_out (serial_readback_out)
   );

   // ---------------------------------------------------------------------
   // Checking helpers
   // ---------------------------------------------------------------------
   // A channel passes only when enabled and the corner code is non-zero
   function automatic logic exp_pass(input logic [7:0] w);
      return chip_enable && (w[7:3] != 5'h00);
   endfunction : exp_pass

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Pins cross three flops plus a filter, so give them time to land first
   task automatic check_word(input logic [7:0] w);
      repeat (12) @(posedge ref_clk);
      #1;
      chk(16'(ch_corner_code), 16'({w[7:3], w[7:3]}));
      chk(16'(ch_gain_code), 16'({w[2:0], w[2:0]}));
      chk(16'({preamp_gain_sel, postamp_gain_sel, vga_max_gain_sel}), 16'(w[2:0]));
      chk(16'(ch_pass), 16'({exp_pass(w), exp_pass(w)}));
      chk(16'({chip_active, offset_loop_active}), 16'({chip_enable, chip_enable & ~offset_loop_disable}));
   endtask : check_word

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict

   // Cut a hang short well beyond the expected run of about 11000 cycles
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 60000) begin
         bad_count++;
         print_verdict();
      end
   end

   // ---------------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------------
   initial begin
      repeat (4) @(posedge ref_clk);
      #1 rstn = 1'b1;
      stored = 8'h00;
      check_word(stored);
      $display("test reset done");
      // Boundary words, then random ones, each read back and re-checked
      for (int n = 0; n < 14; n++) begin
         word = (n < 4) ? corner[n] : 8'($random(seed));
         @(posedge ref_clk);
         #1 offset_loop_disable = 1'($random(seed));
         host.xfer(1'b1, word, 8, rd);
         stored = word;
         check_word(stored);
         host.xfer(1'b0, 8'h00, 8, rd);
         chk(16'(rd), 16'(stored));
         chk(16'(serial_readback_out), 16'h0000);
         check_word(stored);
      end
      $display("test write and read back done");
      host.xfer(1'b1, ~stored, 5, rd);
      check_word(stored);
      $display("test short write done");
      host.stray_clocks(10);
      check_word(stored);
      $display("test stray clocks done");
      @(posedge ref_clk);
      #1 chip_enable = 1'b0;
      host.xfer(1'b1, ~stored, 8, rd);
      check_word(stored);
      @(posedge ref_clk);
      #1 chip_enable = 1'b1;
      check_word(stored);
      $display("test chip disable done");
      // Clock enable low freezes everything, synchronisers included
      @(posedge ref_clk);
      #1 clk_en = 1'b0;
      offset_loop_disable = ~offset_loop_disable;
      repeat (12) @(posedge ref_clk);
      // Frozen loop state still reflects the old pin level, which equals the new pin value
      #1 chk(16'(offset_loop_active), 16'(offset_loop_disable));
      clk_en = 1'b1;
      check_word(stored);
      $display("test clock enable freeze done");
      print_verdict();
   end
endmodule : tb_filter_gain_control_register

// File: verilog/fgc_ctrl.sv
// Serial-programmed control word for the dual filter and gain chain
module fgc_ctrl #(
   parameter int NUM_CH = 2
) (
   input  wire logic                                   ref_clk,
   input  wire logic                                   rstn,
   input  wire logic                                   clk_en,
   input  wire logic                                   latch_enable,
   input  wire logic                                   serial_clk,
   input  wire logic                                   serial_data_in,
   input  wire logic                                   chip_enable,
   input  wire logic                                   offset_loop_disable,
   output logic                                        serial_readback_out,
   output logic [NUM_CH-1:0][fgc_pkg::FREQ_W-1:0]      ch_corner_code,
   output logic [NUM_CH-1:0][fgc_pkg::GAIN_W-1:0]      ch_gain_code,
   output logic [NUM_CH-1:0]                           ch_pass,
   output logic                                        preamp_gain_sel,
   output logic                                        postamp_gain_sel,
   output logic                                        vga_max_gain_sel,
   output logic                                        chip_active,
   output logic                                        offset_loop_active
);

   // ------------------------------------------------------------------------
   // Parameter check
   // ------------------------------------------------------------------------
   if (NUM_CH < 1) begin : g_bad_ch
      $error("fgc_ctrl: at least one channel is needed");
   end

   // ------------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------------
   fgc_pin_if #(.W(fgc_pkg::PIN_W)) pins ();

   assign pins.raw[fgc_pkg::PIN_LE]  = latch_enable;
   assign pins.raw[fgc_pkg::PIN_CLK] = serial_clk;
   assign pins.raw[fgc_pkg::PIN_DIN] = serial_data_in;
   assign pins.raw[fgc_pkg::PIN_CE]  = chip_enable;
   assign pins.raw[fgc_pkg::PIN_OFS] = offset_loop_disable;

   fgc_sync #(.W(fgc_pkg::PIN_W)) u_sync (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .clk_en  (clk_en),
      .pins    (pins)
   );

   logic le_s;      // Clean latch enable
   logic sclk_s;    // Clean serial clock
   logic din_s;     // Clean serial data
   logic chip_s;    // Clean chip enable
   logic ofs_s;     // Clean offset loop disable

   assign le_s   = pins.clean[fgc_pkg::PIN_LE];
   assign sclk_s = pins.clean[fgc_pkg::PIN_CLK];
   assign din_s  = pins.clean[fgc_pkg::PIN_DIN];
   assign chip_s = pins.clean[fgc_pkg::PIN_CE];
   assign ofs_s  = pins.clean[fgc_pkg::PIN_OFS];

   // ------------------------------------------------------------------------
   // Serial port state
   // ------------------------------------------------------------------------
   fgc_pkg::fgc_state_e             state;       // Cycle state
   fgc_pkg::fgc_state_e             next_state;
   logic [2:0]                      bit_cnt;     // Bit index within the cycle
   logic [2:0]                      next_bit_cnt;
   logic [fgc_pkg::WORD_W-1:0]      shift;       // Incoming bits, not yet applied
   logic [fgc_pkg::WORD_W-1:0]      next_shift;
   logic [fgc_pkg::WORD_W-1:0]      ctrl_word;   // The stored control word
   logic [fgc_pkg::WORD_W-1:0]      next_ctrl_word;
   logic                            sclk_prev;   // Serial clock one cycle ago
   logic                            next_sdo;
   logic                            clk_rise;    // Serial clock rising edge seen
   logic                            clk_fall;    // Serial clock falling edge seen

   assign clk_rise = sclk_s & ~sclk_prev;
   assign clk_fall = ~sclk_s & sclk_prev;

   // Cycle sequencing; latch high or chip off closes any cycle at once
   always_comb begin
      next_state     = state;
      next_bit_cnt   = bit_cnt;
      next_shift     = shift;
      next_ctrl_word = ctrl_word;
      next_sdo       = serial_readback_out;
      if (le_s || !chip_s) begin
         // Only a complete write is applied, and only when latch rises
         if (state == fgc_pkg::ST_WDONE && le_s && chip_s) begin
            next_ctrl_word = shift;
         end
         next_state   = fgc_pkg::ST_IDLE;
         next_bit_cnt = 3'h0;
         next_sdo     = 1'b0;
      end else begin
         case (state)
            fgc_pkg::ST_IDLE: begin
               next_state = fgc_pkg::ST_TYPE;
            end
            fgc_pkg::ST_TYPE: begin
               // First rising edge: data high writes, low reads
               if (clk_rise) begin
                  next_state   = din_s ? fgc_pkg::ST_WRITE : fgc_pkg::ST_READ;
                  next_bit_cnt = 3'h0;
               end
            end
            fgc_pkg::ST_WRITE: begin
               // LSB first, so bits enter at the top and walk down
               if (clk_rise) begin
                  next_shift = {din_s, shift[fgc_pkg::WORD_W-1:1]};
                  if (bit_cnt == fgc_pkg::LAST_BIT) begin
                     next_state = fgc_pkg::ST_WDONE;
                  end else begin
                     next_bit_cnt = bit_cnt + 3'h1;
                  end
               end
            end
            fgc_pkg::ST_READ: begin
               // Stored bits go out on falling edges, LSB first
               if (clk_fall) begin
                  next_sdo = ctrl_word[bit_cnt];
                  if (bit_cnt == fgc_pkg::LAST_BIT) begin
                     next_state = fgc_pkg::ST_RDONE;
                  end else begin
                     next_bit_cnt = bit_cnt + 3'h1;
                  end
               end
            end
            default: begin
               // Extra clock edges after eight bits are ignored
               next_state = state;
            end
         endcase
      end
   end

   // Serial port registers
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state               <= fgc_pkg::ST_IDLE;
         bit_cnt             <= 3'h0;
         shift               <= fgc_pkg::RESET_CODE;
         ctrl_word           <= fgc_pkg::RESET_CODE;
         sclk_prev           <= 1'b0;
         serial_readback_out <= 1'b0;
      end else if (clk_en) begin
         state               <= next_state;
         bit_cnt             <= next_bit_cnt;
         shift               <= next_shift;
         ctrl_word           <= next_ctrl_word;
         sclk_prev           <= sclk_s;
         serial_readback_out <= next_sdo;
      end
   end

   // ------------------------------------------------------------------------
   // Applied settings
   // ------------------------------------------------------------------------
   logic [fgc_pkg::FREQ_W-1:0]      freq_now;    // Filter field of the stored word
   logic [fgc_pkg::GAIN_W-1:0]      gain_now;    // Gain field of the stored word
   logic [NUM_CH-1:0][fgc_pkg::FREQ_W-1:0] next_ch_corner_code;
   logic [NUM_CH-1:0][fgc_pkg::GAIN_W-1:0] next_ch_gain_code;
   logic [NUM_CH-1:0]               next_ch_pass;
   logic                            next_offset_active;

   assign freq_now = ctrl_word[fgc_pkg::FREQ_MSB:fgc_pkg::FREQ_LSB];
   assign gain_now = {ctrl_word[fgc_pkg::PRE_BIT], ctrl_word[fgc_pkg::POST_BIT],
                      ctrl_word[fgc_pkg::VGA_BIT]};

   // One word fans out to every channel; there is no per-channel copy
   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         next_ch_corner_code[c] = freq_now;
         next_ch_gain_code[c]   = gain_now;
         next_ch_pass[c]        = chip_s && (freq_now != fgc_pkg::FREQ_OFF);
      end
      next_offset_active = chip_s && !ofs_s;
   end

   // Output registers, so every setting line comes from a flop
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         ch_corner_code     <= '0;
         ch_gain_code       <= '0;
         ch_pass            <= '0;
         preamp_gain_sel    <= 1'b0;
         postamp_gain_sel   <= 1'b0;
         vga_max_gain_sel   <= 1'b0;
         chip_active        <= 1'b0;
         offset_loop_active <= 1'b0;
      end else if (clk_en) begin
         ch_corner_code     <= next_ch_corner_code;
         ch_gain_code       <= next_ch_gain_code;
         ch_pass            <= next_ch_pass;
         preamp_gain_sel    <= gain_now[2];
         postamp_gain_sel   <= gain_now[1];
         vga_max_gain_sel   <= gain_now[0];
         chip_active        <= chip_s;
         offset_loop_active <= next_offset_active;
      end
   end

   // ------------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   logic rd_bit_sel;   // Stored bit that the next read edge should send
   assign rd_bit_sel = ctrl_word[bit_cnt];

   sequence s_write_full;
      clk_en && state == fgc_pkg::ST_WDONE && !le_s && chip_s;
   endsequence
   sequence s_latch_up;
      clk_en && le_s && chip_s;
   endsequence

   a_latch_closes: assert property (clk_en && le_s |=> state == fgc_pkg::ST_IDLE)
      else $error("latch high did not close the cycle");
   a_type_select: assert property (clk_en && state == fgc_pkg::ST_TYPE && clk_rise && !le_s && chip_s
      |=> state == ($past(din_s) ? fgc_pkg::ST_WRITE : fgc_pkg::ST_READ))
      else $error("type bit chose the wrong cycle");
   a_write_commit: assert property (s_write_full ##1 s_latch_up |=> ctrl_word == $past(shift))
      else $error("completed write not applied at latch high");
   a_short_write: assert property (clk_en && state == fgc_pkg::ST_WRITE && le_s |=> $stable(ctrl_word))
      else $error("short write changed the stored word");
   a_read_keeps: assert property (state == fgc_pkg::ST_READ || state == fgc_pkg::ST_RDONE
      |=> $stable(ctrl_word))
      else $error("read changed the stored word");
   a_read_bit: assert property (clk_en && state == fgc_pkg::ST_READ && clk_fall && !le_s && chip_s
      |=> serial_readback_out == $past(rd_bit_sel))
      else $error("read bit does not match the stored word");
   a_field_map: assert property (clk_en |=> ch_corner_code[0] == $past(freq_now)
      && ch_gain_code[0] == $past(gain_now) && preamp_gain_sel == ch_gain_code[0][2])
      else $error("settings do not follow the stored word");
   a_chan_match: assert property (ch_corner_code == {NUM_CH{ch_corner_code[0]}}
      && ch_gain_code == {NUM_CH{ch_gain_code[0]}})
      else $error("channels disagree");
   a_chip_gate: assert property (clk_en && !chip_s |=> ch_pass == '0 && !chip_active)
      else $error("disabled chip still passes signal");
   a_offset_loop: assert property (clk_en |=> offset_loop_active == ($past(chip_s) && !$past(ofs_s)))
      else $error("offset loop state wrong");
   a_zero_blocks: assert property (clk_en && freq_now == fgc_pkg::FREQ_OFF |=> ch_pass == '0)
      else $error("code zero passes signal");

endmodule : fgc_ctrl

// File: verilog/fgc_pin_if.sv
// Bundle carrying raw pin levels into the synchroniser and clean levels back out
interface fgc_pin_if #(
   parameter int W = 5
);
   logic [W-1:0] raw;     // Asynchronous pin levels
   logic [W-1:0] clean;   // Levels after synchronising and agreement filter

   modport sync_side (input raw, output clean);
   modport core_side (output raw, input clean);
endinterface : fgc_pin_if

// File: verilog/fgc_pkg.sv
// Constants, field layout and state encoding of the filter and gain control register
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
package fgc_pkg;

   // ------------------------------------------------------------------------
   // Control word layout
   // ------------------------------------------------------------------------
   localparam int          WORD_W     = 8;           // Width of the control word
   localparam int          FREQ_MSB   = 7;           // Filter code, top bit
   localparam int          FREQ_LSB   = 3;           // Filter code, bottom bit
   localparam int          FREQ_W     = 5;           // Filter code width
   localparam int          PRE_BIT    = 2;           // Preamp gain select
   localparam int          POST_BIT   = 1;           // Postamp gain select
   localparam int          VGA_BIT    = 0;           // VGA max gain select
   localparam int          GAIN_W     = 3;           // Combined digital gain code width
   localparam logic [4:0]  FREQ_OFF   = 5'h00;       // Code that passes no signal
   localparam logic [7:0]  RESET_CODE = 8'h00;       // Value after reset, no signal passed
   localparam logic [2:0]  LAST_BIT   = 3'h7;        // Index of the eighth serial bit

   // ------------------------------------------------------------------------
   // Pin indices inside the synchroniser bundle
   // ------------------------------------------------------------------------
   localparam int          PIN_W      = 5;           // Number of synchronised pins
   localparam int          PIN_LE     = 0;           // Latch enable
   localparam int          PIN_CLK    = 1;           // Serial clock
   localparam int          PIN_DIN    = 2;           // Serial data in
   localparam int          PIN_CE     = 3;           // Chip enable
   localparam int          PIN_OFS    = 4;           // Offset loop disable

   // ------------------------------------------------------------------------
   // Serial port cycle states
   // ------------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,   // Latch high, port closed
      ST_TYPE  = 3'b001,   // Latch low, waiting for the type bit
      ST_WRITE = 3'b010,   // Shifting in data bits
      ST_WDONE = 3'b011,   // Eight bits held, waiting for latch high
      ST_READ  = 3'b100,   // Shifting out stored bits
      ST_RDONE = 3'b101    // All bits sent, waiting for latch high
   } fgc_state_e;

endpackage : fgc_pkg

// File: verilog/fgc_sync.sv
// Three-flop synchroniser with agreement filter for pins outside the ref_clk domain
module fgc_sync #(
   parameter int W = 5
) (
   input  wire logic    ref_clk,
   input  wire logic    rstn,
   input  wire logic    clk_en,
   fgc_pin_if.sync_side pins
);

   // ------------------------------------------------------------------------
   // Parameter check
   // ------------------------------------------------------------------------
   if (W < 1) begin : g_bad_w
      $error("fgc_sync: width must be at least one");
   end

   // ------------------------------------------------------------------------
   // Per-pin stages
   // ------------------------------------------------------------------------
   for (genvar i = 0; i < W; i++) begin : g_pin
      logic s1;            // Metastability catcher, read only by s2
      logic s2;            // Second stage
      logic s3;            // Third stage
      logic cl;            // Filtered level
      logic next_s1;
      logic next_s2;
      logic next_s3;
      logic next_cl;

      // A change counts only once stages two and three agree
      always_comb begin
         next_s1 = pins.raw[i];
         next_s2 = s1;
         next_s3 = s2;
         next_cl = (s2 == s3) ? s3 : cl;
      end

      // Registers; frozen while clock enable is low
      always_ff @(posedge ref_clk) begin
         if (!rstn) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            cl <= 1'b0;
         end else if (clk_en) begin
            s1 <= next_s1;
            s2 <= next_s2;
            s3 <= next_s3;
            cl <= next_cl;
         end
      end

      assign pins.clean[i] = cl;
   end

endmodule : fgc_sync
